//--- rtl/bwc_pkg.sv
package bwc_pkg;
    // Register addresses
    localparam logic [6:0] WD_CONFIG_ADDR   = 7'h03;
    localparam logic [6:0] XCVR_A_ADDR      = 7'h04;
    localparam logic [6:0] XCVR_B_ADDR      = 7'h05;
    localparam logic [6:0] WAKE_A_ADDR      = 7'h06;
    localparam logic [6:0] WAKE_B_ADDR      = 7'h07;
    localparam logic [6:0] WAKE_PULL_ADDR   = 7'h08;

    // Reset values
    localparam logic [7:0] WD_CONFIG_RST    = 8'h14;
    localparam logic [7:0] XCVR_A_RST       = 8'h20;
    localparam logic [7:0] XCVR_B_RST       = 8'h00;
    localparam logic [7:0] WAKE_A_RST       = 8'h00;
    localparam logic [7:0] WAKE_B_RST       = 8'h01;
    localparam logic [7:0] WAKE_PULL_RST    = 8'h00;

    // Writable bits
    localparam logic [7:0] WD_CONFIG_WMASK  = 8'h7F;
    localparam logic [7:0] XCVR_A_WMASK     = 8'hFB;
    localparam logic [7:0] XCVR_B_WMASK     = 8'h03;
    localparam logic [7:0] WAKE_A_WMASK     = 8'h44;
    localparam logic [7:0] WAKE_B_WMASK     = 8'h01;
    localparam logic [7:0] WAKE_PULL_WMASK  = 8'h03;

    // Field positions
    localparam int WD_STOP_DIS_WD_BIT   = 6;
    localparam int WD_WINDOW_BIT        = 5;
    localparam int WD_WAKE_BUS_BIT      = 4;
    localparam int WD_MAX3_BIT          = 3;
    localparam int WD_PERIOD_LSB        = 0;
    localparam int LIN_FLASH_BIT        = 7;
    localparam int LIN_LOW_SLOPE_BIT    = 6;
    localparam int LIN_TX_TO_BIT        = 5;
    localparam int LIN_A_MODE_LSB       = 3;
    localparam int CAN_MODE_LSB         = 0;
    localparam int LIN_B_MODE_LSB       = 0;
    localparam int TIMER_WAKE_BIT       = 6;
    localparam int WD_STOP_DIS_WK_BIT   = 2;
    localparam int WAKE_PIN_EN_BIT      = 0;
    localparam int WAKE_PULL_LSB        = 0;

    // Serial frame layout
    localparam logic [4:0] FRAME_BITS   = 5'd16;
    localparam logic [4:0] HEADER_BITS  = 5'd8;
    localparam int         FRAME_WR_BIT = 7;

    // Watchdog reset limit
    localparam logic [1:0] WD_RESET_LIMIT = 2'd3;

    // Watchdog periods in ms
    localparam logic [9:0] WD_PERIOD_0_MS = 10'd10;
    localparam logic [9:0] WD_PERIOD_1_MS = 10'd20;
    localparam logic [9:0] WD_PERIOD_2_MS = 10'd50;
    localparam logic [9:0] WD_PERIOD_3_MS = 10'd100;
    localparam logic [9:0] WD_PERIOD_4_MS = 10'd200;
    localparam logic [9:0] WD_PERIOD_5_MS = 10'd500;

    // Transceiver mode codes
    typedef enum logic [1:0] {
        BWC_XCVR_OFF     = 2'h0,
        BWC_XCVR_WAKE    = 2'h1,
        BWC_XCVR_RX_ONLY = 2'h2,
        BWC_XCVR_NORMAL  = 2'h3
    } bwc_xcvr_mode_t;

    // Wake pin pull codes
    typedef enum logic [1:0] {
        BWC_PULL_NONE = 2'h0,
        BWC_PULL_DOWN = 2'h1,
        BWC_PULL_UP   = 2'h2,
        BWC_PULL_AUTO = 2'h3
    } bwc_pull_t;
endpackage

//--- rtl/bwc_serial_port.sv
`timescale 1ns/1ps
module bwc_serial_port (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       spi_sclk,
    input  wire logic       spi_csn_n,
    input  wire logic       spi_mosi,
    output logic            spi_miso,
    output logic            spi_miso_oe,
    input  wire logic [7:0] rd_data,
    output logic      [6:0] addr,
    output logic      [7:0] wr_data,
    output logic            wr_pulse
);
    logic [1:0]  sclk_sync;
    logic [1:0]  csn_sync;
    logic [1:0]  mosi_sync;
    logic        sclk_d;
    logic        csn_d;
    logic [4:0]  bit_cnt;
    logic [15:0] frame;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        csn_rise;

    // Two-flop pin synchronisers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_sync <= 2'h0;
            csn_sync  <= 2'h3;
            mosi_sync <= 2'h0;
            sclk_d    <= 1'b0;
            csn_d     <= 1'b1;
        end else begin
            sclk_sync <= {sclk_sync[0], spi_sclk};
            csn_sync  <= {csn_sync[0], spi_csn_n};
            mosi_sync <= {mosi_sync[0], spi_mosi};
            sclk_d    <= sclk_sync[1];
            csn_d     <= csn_sync[1];
        end
    end

    assign sclk_rise = sclk_sync[1] & ~sclk_d & ~csn_sync[1];
    assign sclk_fall = ~sclk_sync[1] & sclk_d & ~csn_sync[1];
    assign csn_rise  = csn_sync[1] & ~csn_d;
    assign addr      = frame[6:0];

    // Shift in LSB first; count saturates
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt <= 5'h00;
            frame   <= 16'h0000;
        end else if (csn_sync[1]) begin
            bit_cnt <= 5'h00;
        end else if (sclk_rise) begin
            if (bit_cnt < bwc_pkg::FRAME_BITS) begin
                frame[bit_cnt[3:0]] <= mosi_sync[1];
            end
            if (bit_cnt <= bwc_pkg::FRAME_BITS) begin
                bit_cnt <= bit_cnt + 5'h01;
            end
        end
    end

    // Read data after header, on falling edges
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            spi_miso <= 1'b0;
        end else if (csn_sync[1]) begin
            spi_miso <= 1'b0;
        end else if (sclk_fall) begin
            if (bit_cnt >= bwc_pkg::HEADER_BITS &&
                bit_cnt < bwc_pkg::FRAME_BITS) begin
                spi_miso <= rd_data[bit_cnt[2:0]];
            end else begin
                spi_miso <= 1'b0;
            end
        end
    end

    assign spi_miso_oe = ~csn_sync[1];

    // Only exact 16-bit frames commit
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pulse <= 1'b0;
            wr_data  <= 8'h00;
        end else begin
            wr_pulse <= csn_rise && bit_cnt == bwc_pkg::FRAME_BITS &&
                        frame[bwc_pkg::FRAME_WR_BIT];
            wr_data  <= frame[15:8];
        end
    end
endmodule

//--- rtl/bwc_regs.sv
`timescale 1ns/1ps
// Operation
// RULE_01: Limit bit: no watchdog reset after three in a row.
// RULE_02: Period codes 0-5 pick 10 to 500 ms; 6, 7 invalid.
// RULE_03: Flash bit turns LIN slope control off.
// RULE_04: Slope bit one picks low slope.
// RULE_05: Time-out bit enables LIN transmit supervision.
// RULE_06: First LIN mode: off, wake, rx-only, normal.
// RULE_07: Second LIN mode: off, wake, rx-only, normal.
// RULE_08: CAN mode: off, wake, rx-only, normal.
// RULE_09: CAN normal runs wake capable in Stop or Sleep.
// RULE_10: LIN normal runs wake capable in Stop or Sleep.
// RULE_11: Stored bits unchanged; normal resumes afterwards.
// RULE_12: Host sets receive-only itself before Stop.
// RULE_13: Host sets CAN wake or off before Sleep.
// RULE_14: Timer wake bit enables periodic timer wake.
// RULE_15: Stop-disable bit halts watchdog in Stop.
// RULE_16: Wake pin enable resets to one.
// RULE_17: Pull field: none, down, up, automatic.
// RULE_18: Reserved bits read zero.
// RULE_19: First transceiver register resets to 0x20.
// RULE_20: Reserved-position writes dropped.
module bwc_regs (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       soft_rst,
    input  wire logic       spi_sclk,
    input  wire logic       spi_csn_n,
    input  wire logic       spi_mosi,
    output logic            spi_miso,
    output logic            spi_miso_oe,
    input  wire logic       stop_mode,
    input  wire logic       sleep_mode,
    input  wire logic       wd_fail,
    input  wire logic       wd_serviced,
    output logic            wd_reset_req,
    output logic      [9:0] wd_period_ms,
    output logic            wd_period_valid,
    output logic            wd_window_en,
    output logic            wd_wake_bus_en,
    output logic            wd_run_in_stop,
    output logic      [1:0] can_mode,
    output logic      [1:0] lin_a_mode,
    output logic      [1:0] lin_b_mode,
    output logic            lin_slope_ctrl_off,
    output logic            lin_low_slope_sel,
    output logic            lin_tx_timeout_en,
    output logic            periodic_timer_wake_en,
    output logic            wake_pin_en,
    output logic      [1:0] wake_pin_pull_sel
);
    logic [7:0] watchdog_config;
    logic [7:0] transceiver_mode_ctrl_a;
    logic [7:0] transceiver_mode_ctrl_b;
    logic [7:0] wake_source_ctrl_a;
    logic [7:0] wake_source_ctrl_b;
    logic [7:0] wake_pin_pull_ctrl;
    logic [6:0] addr;
    logic [7:0] wr_data;
    logic       wr_pulse;
    logic [7:0] rd_data;
    logic       low_power;
    logic       wd_stop_disable;
    logic       wd_parity_ok;
    logic [1:0] wd_reset_cnt;

    // Normal runs as wake capable in low power
    function automatic logic [1:0] bwc_eff_mode(input logic [1:0] stored,
                                                input logic       lp);
        if (lp && stored == bwc_pkg::BWC_XCVR_NORMAL) begin
            return bwc_pkg::BWC_XCVR_WAKE;
        end
        return stored;
    endfunction

    bwc_serial_port u_port (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .spi_sclk    (spi_sclk),
        .spi_csn_n   (spi_csn_n),
        .spi_mosi    (spi_mosi),
        .spi_miso    (spi_miso),
        .spi_miso_oe (spi_miso_oe),
        .rd_data     (rd_data),
        .addr        (addr),
        .wr_data     (wr_data),
        .wr_pulse    (wr_pulse)
    );

    // Odd-parity config bytes are ignored
    assign wd_parity_ok = ~^wr_data;
    // One stop-disable bit, two mirrors
    assign wd_stop_disable = watchdog_config[bwc_pkg::WD_STOP_DIS_WD_BIT];

    // Watchdog config; either mirror moves bit 6
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_config <= bwc_pkg::WD_CONFIG_RST;
        end else if (soft_rst) begin
            watchdog_config <= bwc_pkg::WD_CONFIG_RST;
        end else if (wr_pulse) begin
            if (addr == bwc_pkg::WD_CONFIG_ADDR && wd_parity_ok) begin
                watchdog_config <= wr_data & bwc_pkg::WD_CONFIG_WMASK;
            end else if (addr == bwc_pkg::WAKE_A_ADDR) begin
                watchdog_config[bwc_pkg::WD_STOP_DIS_WD_BIT] <=
                    wr_data[bwc_pkg::WD_STOP_DIS_WK_BIT]; // RULE_15
            end
        end
    end

    // Transceiver registers, reserved bits masked
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            transceiver_mode_ctrl_a <= bwc_pkg::XCVR_A_RST; // RULE_19
            transceiver_mode_ctrl_b <= bwc_pkg::XCVR_B_RST;
        end else if (soft_rst) begin
            transceiver_mode_ctrl_a <= bwc_pkg::XCVR_A_RST; // RULE_19
            transceiver_mode_ctrl_b <= bwc_pkg::XCVR_B_RST;
        end else if (wr_pulse) begin
            if (addr == bwc_pkg::XCVR_A_ADDR) begin
                transceiver_mode_ctrl_a <=
                    wr_data & bwc_pkg::XCVR_A_WMASK; // RULE_20
            end
            if (addr == bwc_pkg::XCVR_B_ADDR) begin
                transceiver_mode_ctrl_b <=
                    wr_data & bwc_pkg::XCVR_B_WMASK; // RULE_20
            end
        end
    end

    // Wake source and pull registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_source_ctrl_a <= bwc_pkg::WAKE_A_RST;
            wake_source_ctrl_b <= bwc_pkg::WAKE_B_RST; // RULE_16
            wake_pin_pull_ctrl <= bwc_pkg::WAKE_PULL_RST;
        end else if (soft_rst) begin
            wake_source_ctrl_a <= bwc_pkg::WAKE_A_RST;
            wake_source_ctrl_b <= bwc_pkg::WAKE_B_RST; // RULE_16
            wake_pin_pull_ctrl <= bwc_pkg::WAKE_PULL_RST;
        end else if (wr_pulse) begin
            if (addr == bwc_pkg::WAKE_A_ADDR) begin
                wake_source_ctrl_a <=
                    wr_data & bwc_pkg::WAKE_A_WMASK; // RULE_20
            end
            if (addr == bwc_pkg::WAKE_B_ADDR) begin
                wake_source_ctrl_b <=
                    wr_data & bwc_pkg::WAKE_B_WMASK; // RULE_20
            end
            if (addr == bwc_pkg::WAKE_PULL_ADDR) begin
                wake_pin_pull_ctrl <=
                    wr_data & bwc_pkg::WAKE_PULL_WMASK; // RULE_20
            end
        end
    end

    // Read mux; unmapped read zero
    always_comb begin
        rd_data = 8'h00;
        unique case (addr)
            bwc_pkg::WD_CONFIG_ADDR:  rd_data = watchdog_config;
            bwc_pkg::XCVR_A_ADDR:     rd_data = transceiver_mode_ctrl_a;
            bwc_pkg::XCVR_B_ADDR:     rd_data = transceiver_mode_ctrl_b;
            bwc_pkg::WAKE_A_ADDR: begin
                rd_data = wake_source_ctrl_a & bwc_pkg::WAKE_A_WMASK;
                rd_data[bwc_pkg::WD_STOP_DIS_WK_BIT] = wd_stop_disable;
            end
            bwc_pkg::WAKE_B_ADDR:     rd_data = wake_source_ctrl_b;
            bwc_pkg::WAKE_PULL_ADDR:  rd_data = wake_pin_pull_ctrl; // RULE_18
            default:                  rd_data = 8'h00;
        endcase
    end

    // Reset limiter; a service rearms it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_reset_cnt <= 2'h0;
            wd_reset_req <= 1'b0;
        end else begin
            wd_reset_req <= 1'b0;
            if (wd_serviced) begin
                wd_reset_cnt <= 2'h0;
            end else if (wd_fail) begin
                if (!watchdog_config[bwc_pkg::WD_MAX3_BIT] ||
                    wd_reset_cnt < bwc_pkg::WD_RESET_LIMIT) begin
                    wd_reset_req <= 1'b1; // RULE_01
                end
                if (wd_reset_cnt < bwc_pkg::WD_RESET_LIMIT) begin
                    wd_reset_cnt <= wd_reset_cnt + 2'h1; // RULE_01
                end
            end
        end
    end

    assign low_power = stop_mode | sleep_mode;

    // Watchdog controls; codes 6, 7 invalid
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_period_ms    <= 10'h000;
            wd_period_valid <= 1'b0;
            wd_window_en    <= 1'b0;
            wd_wake_bus_en  <= 1'b0;
            wd_run_in_stop  <= 1'b1;
        end else begin
            wd_period_valid <= 1'b1;
            unique case (watchdog_config[2:0]) // RULE_02
                3'h0:    wd_period_ms <= bwc_pkg::WD_PERIOD_0_MS;
                3'h1:    wd_period_ms <= bwc_pkg::WD_PERIOD_1_MS;
                3'h2:    wd_period_ms <= bwc_pkg::WD_PERIOD_2_MS;
                3'h3:    wd_period_ms <= bwc_pkg::WD_PERIOD_3_MS;
                3'h4:    wd_period_ms <= bwc_pkg::WD_PERIOD_4_MS;
                3'h5:    wd_period_ms <= bwc_pkg::WD_PERIOD_5_MS;
                default: begin
                    wd_period_ms    <= 10'h000;
                    wd_period_valid <= 1'b0;
                end
            endcase
            wd_window_en   <= watchdog_config[bwc_pkg::WD_WINDOW_BIT];
            wd_wake_bus_en <= watchdog_config[bwc_pkg::WD_WAKE_BUS_BIT];
            wd_run_in_stop <= ~wd_stop_disable; // RULE_15
        end
    end

    // Effective modes; stored bits untouched
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            can_mode   <= bwc_pkg::BWC_XCVR_OFF;
            lin_a_mode <= bwc_pkg::BWC_XCVR_OFF;
            lin_b_mode <= bwc_pkg::BWC_XCVR_OFF;
        end else begin
            can_mode   <= bwc_eff_mode(
                transceiver_mode_ctrl_a[bwc_pkg::CAN_MODE_LSB +: 2],
                low_power); // RULE_08 RULE_09 RULE_11
            lin_a_mode <= bwc_eff_mode(
                transceiver_mode_ctrl_a[bwc_pkg::LIN_A_MODE_LSB +: 2],
                low_power); // RULE_06 RULE_10 RULE_11
            lin_b_mode <= bwc_eff_mode(
                transceiver_mode_ctrl_b[bwc_pkg::LIN_B_MODE_LSB +: 2],
                low_power); // RULE_07 RULE_10 RULE_11
        end
    end

    // LIN options, wake sources, pull
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lin_slope_ctrl_off     <= 1'b0;
            lin_low_slope_sel      <= 1'b0;
            lin_tx_timeout_en      <= 1'b0;
            periodic_timer_wake_en <= 1'b0;
            wake_pin_en            <= 1'b0;
            wake_pin_pull_sel      <= bwc_pkg::BWC_PULL_NONE;
        end else begin
            lin_slope_ctrl_off <=
                transceiver_mode_ctrl_a[bwc_pkg::LIN_FLASH_BIT]; // RULE_03
            lin_low_slope_sel <=
                transceiver_mode_ctrl_a[bwc_pkg::LIN_LOW_SLOPE_BIT]; // RULE_04
            lin_tx_timeout_en <=
                transceiver_mode_ctrl_a[bwc_pkg::LIN_TX_TO_BIT]; // RULE_05
            periodic_timer_wake_en <=
                wake_source_ctrl_a[bwc_pkg::TIMER_WAKE_BIT]; // RULE_14
            wake_pin_en <=
                wake_source_ctrl_b[bwc_pkg::WAKE_PIN_EN_BIT]; // RULE_16
            wake_pin_pull_sel <=
                wake_pin_pull_ctrl[bwc_pkg::WAKE_PULL_LSB +: 2]; // RULE_17
        end
    end
endmodule

//--- tb/bwc_regs_chk.sv
`timescale 1ns/1ps
module bwc_regs_chk (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       soft_rst,
    input  wire logic       spi_csn_n,
    input  wire logic       stop_mode,
    input  wire logic       sleep_mode,
    input  wire logic       wd_fail,
    input  wire logic       wd_serviced,
    input  wire logic       wd_reset_req,
    input  wire logic [9:0] wd_period_ms,
    input  wire logic       wd_period_valid,
    input  wire logic [1:0] can_mode,
    input  wire logic [1:0] lin_a_mode,
    input  wire logic [1:0] lin_b_mode,
    input  wire logic       lin_tx_timeout_en,
    input  wire logic       periodic_timer_wake_en,
    input  wire logic       wake_pin_en,
    input  wire logic [1:0] wake_pin_pull_sel
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Cycles since select rose and since reset, saturating
    logic [3:0] cs_hi;
    logic [1:0] settle;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_hi  <= 4'hF;
            settle <= 2'h0;
        end else begin
            if (!spi_csn_n) cs_hi <= 4'h0;
            else if (cs_hi != 4'hF) cs_hi <= cs_hi + 4'h1;
            if (settle != 2'h3) settle <= settle + 2'h1;
        end
    end

    // Second low-power cycle shows the substitution
    sequence s_low_power;
        (stop_mode || sleep_mode) [*2];
    endsequence
    property p_req_cause;
        wd_reset_req |-> $past(wd_fail) && !$past(wd_serviced);
    endproperty
    property p_can_sub;
        s_low_power |-> can_mode != 2'h3;
    endproperty
    property p_lin_a_sub;
        s_low_power |-> lin_a_mode != 2'h3;
    endproperty
    property p_lin_b_sub;
        s_low_power |-> lin_b_mode != 2'h3;
    endproperty
    property p_period_bad;
        !wd_period_valid |-> wd_period_ms == 10'h000;
    endproperty
    property p_period_ok;
        wd_period_valid |-> wd_period_ms inside {10'h00A, 10'h014,
            10'h032, 10'h064, 10'h0C8, 10'h1F4};
    endproperty
    property p_cfg_quiet;
        !$stable({lin_tx_timeout_en, periodic_timer_wake_en, wake_pin_en,
            wake_pin_pull_sel}) |-> (cs_hi inside {[1:12]}) ||
            $past(soft_rst) || $past(soft_rst, 2) || settle != 2'h3;
    endproperty
    property p_soft_reload;
        soft_rst |-> ##2 (wake_pin_en && lin_tx_timeout_en &&
            can_mode == 2'h0 && wd_period_ms == 10'h0C8);
    endproperty

    a_req_cause: assert property (p_req_cause)
        else $error("request without a failure");
    a_can_sub: assert property (p_can_sub)
        else $error("CAN normal in low power");
    a_lin_a_sub: assert property (p_lin_a_sub)
        else $error("LIN A normal in low power");
    a_lin_b_sub: assert property (p_lin_b_sub)
        else $error("LIN B normal in low power");
    a_period_bad: assert property (p_period_bad)
        else $error("invalid code shows a period");
    a_period_ok: assert property (p_period_ok)
        else $error("period not a listed value");
    a_cfg_quiet: assert property (p_cfg_quiet)
        else $error("config moved without a write");
    a_soft_reload: assert property (p_soft_reload)
        else $error("soft reset not reloaded");
endmodule

//--- tb/bwc_host_model.sv
`timescale 1ns/1ps
// Serial host master
module bwc_host_model (
    input  wire logic core_clk,
    input  wire logic spi_miso,
    output logic      spi_sclk,
    output logic      spi_csn_n,
    output logic      spi_mosi
);
    localparam int HALF = 5; // Above the 4-cycle minimum

    initial begin
        spi_sclk  = 1'b0;
        spi_csn_n = 1'b1;
        spi_mosi  = 1'b0;
    end

    task automatic gap(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // One frame, bit 0 first
    task automatic xfer(input logic [6:0] a, input logic wr,
                        input logic [7:0] d, output logic [7:0] q);
        logic [15:0] f;
        f = {d, wr, a};
        q = 8'h00;
        gap(1);
        spi_csn_n <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            spi_mosi <= f[i];
            gap(HALF);
            spi_sclk <= 1'b1;
            if (i > 7) q[i-8] = spi_miso; // Settled since the last fall
            gap(HALF);
            spi_sclk <= 1'b0;
        end
        gap(HALF);
        spi_csn_n <= 1'b1;
        spi_mosi  <= ~f[15]; // No stale data
        gap(12); // Let the commit land
    endtask
endmodule

//--- tb/bus_wake_control_regs_bench.sv
`timescale 1ns/1ps
module bus_wake_control_regs_bench;
    logic       core_clk, rst_n, soft_rst, stop_mode, sleep_mode;
    logic       wd_fail, wd_serviced, spi_sclk, spi_csn_n, spi_mosi;
    logic       spi_miso, wd_reset_req, wd_period_valid, wd_run_in_stop;
    logic       lin_slope_ctrl_off, lin_low_slope_sel, lin_tx_timeout_en;
    logic       periodic_timer_wake_en, wake_pin_en;
    logic [9:0] wd_period_ms;
    logic [1:0] can_mode, lin_a_mode, lin_b_mode, wake_pin_pull_sel;
    logic [7:0] q;
    int         bad_count, check_count, req_seen;

    bwc_regs DUT (.core_clk(core_clk), .rst_n(rst_n), .soft_rst(soft_rst),
        .spi_sclk(spi_sclk), .spi_csn_n(spi_csn_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe(), .stop_mode(stop_mode),
        .sleep_mode(sleep_mode), .wd_fail(wd_fail),
        .wd_serviced(wd_serviced), .wd_reset_req(wd_reset_req),
        .wd_period_ms(wd_period_ms), .wd_period_valid(wd_period_valid),
        .wd_window_en(), .wd_wake_bus_en(), .wd_run_in_stop(wd_run_in_stop),
        .can_mode(can_mode), .lin_a_mode(lin_a_mode),
        .lin_b_mode(lin_b_mode), .lin_slope_ctrl_off(lin_slope_ctrl_off),
        .lin_low_slope_sel(lin_low_slope_sel),
        .lin_tx_timeout_en(lin_tx_timeout_en),
        .periodic_timer_wake_en(periodic_timer_wake_en),
        .wake_pin_en(wake_pin_en), .wake_pin_pull_sel(wake_pin_pull_sel));
    bwc_host_model host (.core_clk(core_clk), .spi_miso(spi_miso),
        .spi_sclk(spi_sclk), .spi_csn_n(spi_csn_n), .spi_mosi(spi_mosi));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Requests seen
    always @(posedge core_clk) begin
        if (wd_reset_req === 1'b1) req_seen <= req_seen + 1;
    end

    task automatic check(input string nm, input logic [9:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.xfer(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        host.xfer(a, 1'b0, 8'h00, q);
        check($sformatf("reg %0h", a), 10'(q), 10'(e));
    endtask
    // One watchdog event
    task automatic pulse(input logic svc);
        @(posedge core_clk);
        wd_serviced <= svc;
        wd_fail     <= ~svc;
        @(posedge core_clk);
        wd_serviced <= 1'b0;
        wd_fail     <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic lp(input logic st, sl);
        stop_mode  <= st;
        sleep_mode <= sl;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Run is about 9.3k cycles
    initial begin
        #200000;
        bad_count++;
        summarize();
    end

    initial begin
        logic [7:0] rv [7] = '{8'h14, 8'h20, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
        logic [7:0] wm [7] = '{8'h00, 8'hFB, 8'h03, 8'h44, 8'h01, 8'h03, 8'h00};
        logic [9:0] ms [8] = '{10'h00A, 10'h014, 10'h032, 10'h064, 10'h0C8,
                               10'h1F4, 10'h000, 10'h000};
        logic [1:0] m;
        logic [7:0] d;
        rst_n = 1'b0;
        soft_rst = 1'b0;
        stop_mode = 1'b0;
        sleep_mode = 1'b0;
        wd_fail = 1'b0;
        wd_serviced = 1'b0;
        req_seen = 0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        // Defaults, then all ones
        for (int i = 0; i < 7; i++) rd(7'(i + 3), rv[i]);
        for (int i = 1; i < 7; i++) begin
            wr(7'(i + 3), 8'hFF);
            rd(7'(i + 3), wm[i]);
        end
        rd(7'h03, 8'h54);
        check("slope off", 10'(lin_slope_ctrl_off), 10'h001);
        check("low slope", 10'(lin_low_slope_sel), 10'h001);
        check("tx timeout", 10'(lin_tx_timeout_en), 10'h001);
        check("timer wake", 10'(periodic_timer_wake_en), 10'h001);
        check("wd in stop", 10'(wd_run_in_stop), 10'h000);
        // Normal drops to wake in Stop and Sleep; rx-only stays in Stop
        lp(1'b1, 1'b0);
        check("can stop", 10'(can_mode), 10'h001);
        check("lin a stop", 10'(lin_a_mode), 10'h001);
        check("lin b stop", 10'(lin_b_mode), 10'h001);
        rd(7'h04, 8'hFB);
        lp(1'b0, 1'b0);
        check("can back", 10'(can_mode), 10'h003);
        check("lin a back", 10'(lin_a_mode), 10'h003);
        wr(7'h04, 8'h19);
        lp(1'b0, 1'b1);
        check("lin a sleep", 10'(lin_a_mode), 10'h001);
        check("lin b sleep", 10'(lin_b_mode), 10'h001);
        lp(1'b0, 1'b0);
        wr(7'h04, 8'h12);
        lp(1'b1, 1'b0);
        check("can rx stop", 10'(can_mode), 10'h002);
        check("lin rx stop", 10'(lin_a_mode), 10'h002);
        lp(1'b0, 1'b0);
        // Every mode and pull code
        for (int k = 0; k < 4; k++) begin
            m = 2'(k);
            wr(7'h04, {3'h0, m, 1'b0, m});
            wr(7'h05, {6'h00, m});
            wr(7'h08, {6'h00, m});
            check("can", 10'(can_mode), 10'(m));
            check("lin a", 10'(lin_a_mode), 10'(m));
            check("lin b", 10'(lin_b_mode), 10'(m));
            check("pull", 10'(wake_pin_pull_sel), 10'(m));
        end
        wr(7'h04, 8'h40);
        check("slope on", 10'(lin_slope_ctrl_off), 10'h000);
        check("tx timeout off", 10'(lin_tx_timeout_en), 10'h000);
        wr(7'h06, 8'h00);
        wr(7'h07, 8'h00);
        check("wake pin", 10'(wake_pin_en), 10'h000);
        check("no timer", 10'(periodic_timer_wake_en), 10'h000);
        check("wd runs", 10'(wd_run_in_stop), 10'h001);
        // Every period code, even checksum
        for (int c = 0; c < 8; c++) begin
            d = {^c[2:0], 4'h0, c[2:0]};
            wr(7'h03, d);
            check("period", wd_period_ms, ms[c]);
            check("valid", 10'(wd_period_valid), 10'(c < 6));
        end
        wr(7'h03, 8'h01);
        rd(7'h03, 8'h07);
        // Limiter on, then off
        wr(7'h03, 8'h88);
        repeat (4) pulse(1'b0);
        check("limited", 10'(req_seen), 10'h003);
        pulse(1'b1);
        pulse(1'b0);
        wr(7'h03, 8'h00);
        repeat (4) pulse(1'b0);
        check("unlimited", 10'(req_seen), 10'h008);
        @(posedge core_clk);
        soft_rst <= 1'b1;
        @(posedge core_clk);
        soft_rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        rd(7'h04, 8'h20);
        rd(7'h07, 8'h01);
        summarize();
    end
endmodule

bind bwc_regs bwc_regs_chk u_chk (.core_clk(core_clk), .rst_n(rst_n),
    .soft_rst(soft_rst), .spi_csn_n(spi_csn_n), .stop_mode(stop_mode),
    .sleep_mode(sleep_mode), .wd_fail(wd_fail), .wd_serviced(wd_serviced),
    .wd_reset_req(wd_reset_req), .wd_period_ms(wd_period_ms),
    .wd_period_valid(wd_period_valid), .can_mode(can_mode),
    .lin_a_mode(lin_a_mode), .lin_b_mode(lin_b_mode),
    .lin_tx_timeout_en(lin_tx_timeout_en),
    .periodic_timer_wake_en(periodic_timer_wake_en),
    .wake_pin_en(wake_pin_en), .wake_pin_pull_sel(wake_pin_pull_sel));
